// file: hw/fpcf_flash_protect.sv
`timescale 1ns/1ps
module fpcf_flash_protect
  import fpcf_pkg::*;
(
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              reset_n,
  // host serial pins
  input  wire logic              cs_n,
  input  wire logic              serial_clk,
  input  wire logic              serial_data_in,
  // protection settings
  input  wire logic              protect_scheme_select,
  input  wire logic              complement_protect,
  input  wire logic              sector_granularity,
  input  wire logic              top_bottom_select,
  input  wire logic              block_protect_2,
  input  wire logic              block_protect_1,
  input  wire logic              block_protect_0,
  // array path status
  input  wire logic              array_busy,
  // array path requests
  output logic                   erase_req,
  output logic [ADDR_W-1:0]      erase_addr,
  output logic [1:0]             erase_size,
  output logic                   prog_req,
  output logic [ADDR_W-1:0]      prog_addr,
  output logic [7:0]             prog_data,
  output logic                   prog_data_valid,
  output logic                   cmd_rejected
);

  logic [2:0]        cs_sync_reg, sck_sync_reg, data_sync_reg;
  logic              cs_f_reg, sck_f_reg, data_f_reg;
  logic              cs_f_next, sck_f_next, data_f_next;
  logic              cs_fall, cs_rise, sck_rise;
  fpcf_frame_e       frame_reg;
  logic [2:0]        bit_cnt_reg, byte_cnt_reg;
  logic [7:0]        shift_reg, shift_next, opcode_reg;
  logic [23:0]       addr_reg;
  logic              frame_busy_reg, first_cyc_reg;
  logic [LOCK_UNITS-1:0] lock_reg;
  logic [2:0]        bp;
  logic [22:0]       base_size;
  logic [21:0]       base_lo, base_hi, reg_lo, reg_hi;
  logic              base_none, base_all, overlap, contained;
  logic              status_hit, lock_hit, region_prot;
  logic              is_erase, is_prog, is_lock, is_glb, write_op;
  logic              aligned, enough, frame_ok, byte_done;
  logic [6:0]        addr_unit;

  // three-stage sync; a change counts once stages two and three agree
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cs_sync_reg   <= SYNC_IDLE_CS;
      sck_sync_reg  <= 3'h0;
      data_sync_reg <= 3'h0;
      cs_f_reg      <= 1'b1;
      sck_f_reg     <= 1'b0;
      data_f_reg    <= 1'b0;
    end else begin
      cs_sync_reg   <= {cs_sync_reg[1:0], cs_n};
      sck_sync_reg  <= {sck_sync_reg[1:0], serial_clk};
      data_sync_reg <= {data_sync_reg[1:0], serial_data_in};
      cs_f_reg      <= cs_f_next;
      sck_f_reg     <= sck_f_next;
      data_f_reg    <= data_f_next;
    end
  end

  assign cs_f_next  = (cs_sync_reg[1] == cs_sync_reg[2]) ?
                      cs_sync_reg[2] : cs_f_reg;
  assign sck_f_next = (sck_sync_reg[1] == sck_sync_reg[2]) ?
                      sck_sync_reg[2] : sck_f_reg;
  assign data_f_next = (data_sync_reg[1] == data_sync_reg[2]) ?
                       data_sync_reg[2] : data_f_reg;
  assign cs_fall    = cs_f_reg & ~cs_f_next;
  assign cs_rise    = ~cs_f_reg & cs_f_next;
  assign sck_rise   = ~sck_f_reg & sck_f_next & ~cs_f_next;
  assign shift_next = {shift_reg[6:0], data_f_next};
  assign byte_done  = sck_rise && (frame_reg == FR_ACTIVE) &&
                      (bit_cnt_reg == 3'h7);

  // opcode classes
  assign is_erase = (opcode_reg == OP_SECTOR_ERASE) ||
                    (opcode_reg == OP_BLK32_ERASE) ||
                    (opcode_reg == OP_BLK64_ERASE) ||
                    (opcode_reg == OP_CHIP_ERASE_A) ||
                    (opcode_reg == OP_CHIP_ERASE_B);
  assign is_prog  = (opcode_reg == OP_PAGE_PROG);
  assign is_lock  = (opcode_reg == OP_BLK_LOCK) ||
                    (opcode_reg == OP_BLK_UNLOCK);
  assign is_glb   = (opcode_reg == OP_GLB_LOCK) ||
                    (opcode_reg == OP_GLB_UNLOCK);
  assign write_op = is_erase || is_prog || is_lock || is_glb;

  // region that the pending command touches
  always_comb begin
    reg_lo = addr_reg[21:0] & ~SECTOR_MASK;
    reg_hi = addr_reg[21:0] | SECTOR_MASK;
    unique case (opcode_reg)
      OP_BLK32_ERASE: begin
        reg_lo = addr_reg[21:0] & ~BLOCK32_MASK;
        reg_hi = addr_reg[21:0] | BLOCK32_MASK;
      end
      OP_BLK64_ERASE: begin
        reg_lo = addr_reg[21:0] & ~BLOCK_MASK;
        reg_hi = addr_reg[21:0] | BLOCK_MASK;
      end
      OP_CHIP_ERASE_A, OP_CHIP_ERASE_B: begin
        reg_lo = ARRAY_FIRST;
        reg_hi = ARRAY_LAST;
      end
      // a page program stays inside the page it starts in
      OP_PAGE_PROG: begin
        reg_lo = addr_reg[21:0];
        reg_hi = addr_reg[21:0] | PAGE_MASK;
      end
      default: begin
        reg_lo = addr_reg[21:0] & ~SECTOR_MASK;
        reg_hi = addr_reg[21:0] | SECTOR_MASK;
      end
    endcase
  end

  // status-bit protected range, before the complement
  assign bp        = {block_protect_2, block_protect_1, block_protect_0};
  assign base_none = (bp == 3'h0);
  assign base_all  = (bp == 3'h7);
  always_comb begin
    base_size = BLOCK_SIZE;
    if (base_none || base_all)
      base_size = ARRAY_SIZE;
    else if (!sector_granularity)
      base_size = 23'(BLOCK_SIZE << (bp - 3'h1));
    else if (bp[2])
      base_size = BLOCK32_SIZE;
    else
      base_size = 23'(SECTOR_SIZE << (bp[1:0] - 2'h1));
  end
  assign base_lo   = top_bottom_select ? ARRAY_FIRST :
                     22'(ARRAY_SIZE - base_size);
  assign base_hi   = top_bottom_select ? 22'(base_size - 23'h1) :
                     ARRAY_LAST;
  assign overlap   = (reg_lo <= base_hi) && (reg_hi >= base_lo);
  assign contained = (reg_lo >= base_lo) && (reg_hi <= base_hi);
  // complement: protected set is everything outside the base range
  assign status_hit = complement_protect ?
    (base_none || (!base_all && !contained)) :
    (base_all || (!base_none && overlap));

  // lock-bit hit over the region
  always_comb begin
    logic [21:0] ulo, uhi;
    ulo      = ARRAY_FIRST;
    uhi      = ARRAY_FIRST;
    lock_hit = 1'b0;
    for (int i = 0; i < LOCK_UNITS; i++) begin
      if (i < LOCK_MID_BASE) begin
        ulo = 22'(i * int'(SECTOR_SIZE));
        uhi = ulo | SECTOR_MASK;
      end else if (i < LOCK_TOP_BASE) begin
        ulo = 22'((i - LOCK_MID_BASE + 1) * int'(BLOCK_SIZE));
        uhi = ulo | BLOCK_MASK;
      end else begin
        ulo = TOP_BLOCK_BASE |
              22'((i - LOCK_TOP_BASE) * int'(SECTOR_SIZE));
        uhi = ulo | SECTOR_MASK;
      end
      if (lock_reg[i] && ulo <= reg_hi && uhi >= reg_lo)
        lock_hit = 1'b1;
    end
  end

  assign region_prot = protect_scheme_select ? lock_hit : status_hit;

  // lock unit addressed by a single-unit lock command
  always_comb begin
    if (addr_reg[21:16] == BLOCK_BOTTOM)
      addr_unit = {3'h0, addr_reg[15:12]};
    else if (addr_reg[21:16] == BLOCK_TOP)
      addr_unit = LOCK_TOP_OFS + {3'h0, addr_reg[15:12]};
    else
      addr_unit = LOCK_MID_OFS + {1'b0, addr_reg[21:16]};
  end

  // frame closing checks
  assign aligned  = (bit_cnt_reg == 3'h0);
  assign enough   = is_prog  ? (byte_cnt_reg >= BYTE_FIRST_DATA) :
                    is_glb   ? 1'b1 :
                    (opcode_reg == OP_CHIP_ERASE_A ||
                     opcode_reg == OP_CHIP_ERASE_B) ? 1'b1 :
                    (byte_cnt_reg >= BYTE_ADDR_DONE);
  assign frame_ok = cs_rise && (frame_reg == FR_ACTIVE) && write_op &&
                    aligned && enough && !frame_busy_reg &&
                    !array_busy;

  // frame tracking
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      frame_reg      <= FR_IDLE;
      bit_cnt_reg    <= 3'h0;
      byte_cnt_reg   <= 3'h0;
      shift_reg      <= 8'h00;
      opcode_reg     <= 8'h00;
      addr_reg       <= 24'h000000;
      frame_busy_reg <= 1'b0;
    end else begin
      unique case (frame_reg)
        FR_IDLE: begin
          if (cs_fall) begin
            frame_reg      <= FR_ACTIVE;
            bit_cnt_reg    <= 3'h0;
            byte_cnt_reg   <= 3'h0;
            opcode_reg     <= 8'h00;
            frame_busy_reg <= array_busy;
          end
        end
        FR_ACTIVE: begin
          frame_busy_reg <= frame_busy_reg | array_busy;
          if (cs_rise) begin
            frame_reg <= FR_IDLE;
          end else if (sck_rise) begin
            shift_reg   <= shift_next;
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            if (bit_cnt_reg == 3'h7) begin
              if (byte_cnt_reg != BYTE_SAT)
                byte_cnt_reg <= byte_cnt_reg + 3'h1;
              if (byte_cnt_reg == 3'h0)
                opcode_reg <= shift_next;
              else if (byte_cnt_reg < BYTE_ADDR_DONE)
                addr_reg <= {addr_reg[15:0], shift_next};
            end
          end
        end
      endcase
    end
  end

  // lock bits: reset value is all locked
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      lock_reg <= LOCK_RESET;
    end else if (frame_ok && is_glb) begin
      lock_reg <= {LOCK_UNITS{opcode_reg == OP_GLB_LOCK}};
    end else if (frame_ok && is_lock) begin
      lock_reg[addr_unit] <= (opcode_reg == OP_BLK_LOCK);
    end
  end

  // array requests
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      erase_req    <= 1'b0;
      erase_addr   <= '0;
      erase_size   <= ER_4K;
      prog_req     <= 1'b0;
      prog_addr    <= '0;
      cmd_rejected <= 1'b0;
    end else begin
      erase_req    <= frame_ok && is_erase && !region_prot;
      prog_req     <= frame_ok && is_prog && !region_prot;
      cmd_rejected <= cs_rise && (frame_reg == FR_ACTIVE) && write_op &&
                      !(frame_ok && !((is_erase || is_prog) && region_prot));
      if (frame_ok && is_erase) begin
        erase_addr <= reg_lo;
        erase_size <= (opcode_reg == OP_SECTOR_ERASE) ? ER_4K  :
                      (opcode_reg == OP_BLK32_ERASE) ? ER_32K :
                      (opcode_reg == OP_BLK64_ERASE) ? ER_64K : ER_CHIP;
      end
      if (frame_ok && is_prog)
        prog_addr <= reg_lo;
    end
  end

  // data bytes only load the page buffer; nothing is written without prog_req
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      prog_data       <= 8'h00;
      prog_data_valid <= 1'b0;
    end else begin
      prog_data_valid <= byte_done && is_prog && !frame_busy_reg &&
                         (byte_cnt_reg >= BYTE_ADDR_DONE);
      if (byte_done)
        prog_data <= shift_next;
    end
  end

  // checks
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n)
      first_cyc_reg <= 1'b1;
    else
      first_cyc_reg <= 1'b0;
  end

  a_locks_after_reset: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    first_cyc_reg |-> (lock_reg == LOCK_RESET))
    else $error("lock bits not all set after reset");
  a_protect_blocks: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (cs_rise && region_prot && (is_erase || is_prog)) |=>
      (!erase_req && !prog_req && cmd_rejected))
    else $error("protected region erased or programmed");
  a_boundary_only: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (cs_rise && !aligned && write_op) |=> (!erase_req && !prog_req))
    else $error("unaligned write frame accepted");
  a_busy_ignores: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (cs_rise && array_busy) |=> ($stable(lock_reg) && !erase_req &&
                                 !prog_req))
    else $error("command accepted while busy");
  a_cmp_inverse: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (!protect_scheme_select && complement_protect && !base_none &&
     !base_all) |-> (region_prot == !contained))
    else $error("complement map wrong");
  a_scheme_source: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    !protect_scheme_select |-> (region_prot == status_hit))
    else $error("lock bits used under scheme zero");
  a_opcode_capture: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (byte_done && byte_cnt_reg == 3'h0 && !cs_rise) |=>
      (opcode_reg == $past(shift_next)))
    else $error("opcode not taken from first byte");
  a_frame_start: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (cs_fall && frame_reg == FR_IDLE) |=>
      (frame_reg == FR_ACTIVE && bit_cnt_reg == 3'h0 &&
       byte_cnt_reg == 3'h0))
    else $error("frame not restarted on select fall");
  a_read_abort: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (cs_rise && (opcode_reg == OP_READ || opcode_reg == OP_FAST_READ)) |=>
      (!cmd_rejected && !erase_req && !prog_req && frame_reg == FR_IDLE))
    else $error("read termination mishandled");

endmodule // fpcf_flash_protect

// file: hw/fpcf_pkg.sv
package fpcf_pkg;
  // instruction opcodes handled by the framing logic
  localparam logic [7:0]  OP_PAGE_PROG    = 8'h02;
  localparam logic [7:0]  OP_READ         = 8'h03;
  localparam logic [7:0]  OP_READ_STATUS  = 8'h05;
  localparam logic [7:0]  OP_FAST_READ    = 8'h0b;
  localparam logic [7:0]  OP_SECTOR_ERASE = 8'h20;
  localparam logic [7:0]  OP_BLK32_ERASE  = 8'h52;
  localparam logic [7:0]  OP_BLK64_ERASE  = 8'hd8;
  localparam logic [7:0]  OP_CHIP_ERASE_A = 8'hc7;
  localparam logic [7:0]  OP_CHIP_ERASE_B = 8'h60;
  localparam logic [7:0]  OP_BLK_LOCK     = 8'h36;
  localparam logic [7:0]  OP_BLK_UNLOCK   = 8'h39;
  localparam logic [7:0]  OP_GLB_LOCK     = 8'h7e;
  localparam logic [7:0]  OP_GLB_UNLOCK   = 8'h98;
  // array geometry
  localparam int          ADDR_W          = 22;
  localparam logic [21:0] ARRAY_FIRST     = 22'h000000;
  localparam logic [21:0] ARRAY_LAST      = 22'h3fffff;
  localparam logic [22:0] ARRAY_SIZE      = 23'h400000;
  localparam logic [22:0] SECTOR_SIZE     = 23'h001000;
  localparam logic [22:0] BLOCK32_SIZE    = 23'h008000;
  localparam logic [22:0] BLOCK_SIZE      = 23'h010000;
  localparam logic [21:0] SECTOR_MASK     = 22'h000fff;
  localparam logic [21:0] BLOCK32_MASK    = 22'h007fff;
  localparam logic [21:0] BLOCK_MASK      = 22'h00ffff;
  localparam logic [21:0] PAGE_MASK       = 22'h0000ff;
  localparam logic [5:0]  BLOCK_TOP       = 6'h3f;
  localparam logic [5:0]  BLOCK_BOTTOM    = 6'h00;
  // lock units: 16 sectors of block 0, blocks 1..62, 16 sectors of block 63
  localparam int          LOCK_UNITS      = 94;
  localparam int          LOCK_MID_BASE   = 16;
  localparam int          LOCK_TOP_BASE   = 78;
  localparam logic [6:0]  LOCK_MID_OFS    = 7'h0f;
  localparam logic [6:0]  LOCK_TOP_OFS    = 7'h4e;
  localparam logic [21:0] TOP_BLOCK_BASE  = 22'h3f0000;
  localparam logic [93:0] LOCK_RESET      = {94{1'b1}};
  // frame counters
  localparam logic [2:0]  BYTE_ADDR_DONE  = 3'h4;
  localparam logic [2:0]  BYTE_FIRST_DATA = 3'h5;
  localparam logic [2:0]  BYTE_SAT        = 3'h7;
  localparam logic [2:0]  SYNC_IDLE_CS    = 3'h7;
  // erase size codes on erase_size
  localparam logic [1:0]  ER_4K           = 2'h0;
  localparam logic [1:0]  ER_32K          = 2'h1;
  localparam logic [1:0]  ER_64K          = 2'h2;
  localparam logic [1:0]  ER_CHIP         = 2'h3;
  typedef enum logic [1:0] {FR_IDLE = 2'b01, FR_ACTIVE = 2'b10} fpcf_frame_e;
endpackage

// file: sim/fpcf_host_model.sv
`timescale 1ns/1ps
module fpcf_host_model (
  // clock
  input  wire logic core_clk,
  // serial pins
  output logic      cs_n,
  output logic      serial_clk,
  output logic      serial_data_in
);
  initial begin
    cs_n           = 1'b1;
    serial_clk     = 1'b0;
    serial_data_in = 1'b0;
  end
  // every level holds 4 cycles so the pin filter always sees it
  task automatic send(input int nbits, input logic [63:0] fr);
    @(posedge core_clk);
    cs_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    for (int i = 0; i < nbits; i++) begin
      serial_data_in <= fr[63-i];
      repeat (4) @(posedge core_clk);
      serial_clk <= 1'b1;
      repeat (4) @(posedge core_clk);
      serial_clk <= 1'b0;
    end
    repeat (4) @(posedge core_clk);
    cs_n           <= 1'b1;
    // released line shows the inverse, never the last bit
    serial_data_in <= ~serial_data_in;
    repeat (4) @(posedge core_clk);
  endtask
endmodule // fpcf_host_model

// file: sim/tb.sv
`timescale 1ns/1ps
module tb
  import fpcf_pkg::*;
;
  logic core_clk, reset_n, scheme, cpl, gran, tbs, busy;
  logic [2:0] bp;
  logic cs_n, sclk, sdi, er, pr, pv, rj;
  logic [1:0] es;
  logic [21:0] ea, pa, last_ea;
  logic [7:0] pd;
  logic [1:0] last_es;
  logic [15:0] lf;
  int error_cnt, n_compared, n_er, n_rj, n_pr, n_pv;
  logic [7:0] ops [5];
  logic [1:0] szc [5];

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  fpcf_host_model u_host (.core_clk(core_clk), .cs_n(cs_n),
    .serial_clk(sclk), .serial_data_in(sdi));
  fpcf_flash_protect u_dut (.core_clk(core_clk), .reset_n(reset_n),
    .cs_n(cs_n), .serial_clk(sclk), .serial_data_in(sdi),
    .protect_scheme_select(scheme), .complement_protect(cpl),
    .sector_granularity(gran), .top_bottom_select(tbs),
    .block_protect_2(bp[2]), .block_protect_1(bp[1]),
    .block_protect_0(bp[0]), .array_busy(busy), .erase_req(er),
    .erase_addr(ea), .erase_size(es), .prog_req(pr), .prog_addr(pa),
    .prog_data(pd), .prog_data_valid(pv), .cmd_rejected(rj));

  // pulse counters; addresses captured at the pulse itself
  always @(posedge core_clk) begin
    if (er === 1'b1) begin
      n_er++;
      last_ea = ea;
      last_es = es;
    end
    if (rj === 1'b1) n_rj++;
    if (pr === 1'b1) n_pr++;
    if (pv === 1'b1) n_pv++;
  end

  task automatic complete_run();
    $display("compared %0d, errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk_cnt(input string nm, input int e, input int g);
    n_compared++;
    if (e != g) begin
      error_cnt++;
      $display("[ERR] %s expected %0d seen %0d", nm, e, g);
    end
  endtask

  task automatic chk_vec(input string nm, input logic [23:0] e,
                         input logic [23:0] g);
    n_compared++;
    if (e !== g) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic int rsize(input logic [7:0] op);
    case (op)
      OP_SECTOR_ERASE: return 32'h1000;
      OP_BLK32_ERASE: return 32'h8000;
      OP_BLK64_ERASE: return 32'h10000;
      OP_PAGE_PROG:   return 32'h100;
      default:        return 32'h400000;
    endcase
  endfunction

  // does [lo,hi] touch the status-bit protected area
  function automatic bit hits(input int lo, input int hi);
    int sz, plo, phi;
    sz = 32'h400000;
    if (bp != 3'h0 && bp != 3'h7)
      sz = !gran ? (32'h10000 << (bp - 1)) :
           (bp >= 3'h4) ? 32'h8000 : (32'h1000 << (bp - 1));
    plo = tbs ? 0 : 32'h400000 - sz;
    phi = plo + sz - 1;
    if (!cpl) return bp != 3'h0 && lo <= phi && hi >= plo;
    return bp == 3'h0 || lo < plo || hi > phi;
  endfunction

  task automatic frame(input int nbits, input logic [63:0] fr,
                       input int e_er, input int e_rj, input int e_pr,
                       input int e_pv);
    int b_er, b_rj, b_pr, b_pv;
    b_er = n_er;
    b_rj = n_rj;
    b_pr = n_pr;
    b_pv = n_pv;
    u_host.send(nbits, fr);
    repeat (6) @(posedge core_clk);
    chk_cnt("erase_req", e_er, n_er - b_er);
    chk_cnt("cmd_rejected", e_rj, n_rj - b_rj);
    chk_cnt("prog_req", e_pr, n_pr - b_pr);
    chk_cnt("prog_data_valid", e_pv, n_pv - b_pv);
  endtask

  task automatic erase(input int k, input logic [21:0] a, input bit ok);
    int sz;
    sz = rsize(ops[k]);
    frame(32, {ops[k], 2'h0, a, 32'h0}, ok, !ok, 0, 0);
    if (ok) chk_vec("erase_size", {22'h0, szc[k]}, {22'h0, last_es});
    if (ok && k < 3)
      chk_vec("erase_addr", {2'h0, a & ~(sz[21:0] - 22'h1)},
              {2'h0, last_ea});
  endtask

  task automatic set_prot(input logic w, input logic c, input logic s,
                          input logic t, input logic [2:0] b);
    @(posedge core_clk);
    scheme <= w;
    cpl    <= c;
    gran   <= s;
    tbs <= t;
    bp  <= b;
  endtask

  task automatic do_reset();
    @(posedge core_clk);
    reset_n <= 1'b0;
    repeat (16) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge core_clk);
  endtask

  initial begin
    #900000;
    error_cnt++;
    complete_run();
  end

  initial begin
    int k, lo, hi;
    logic [21:0] a;
    {scheme, cpl, gran, tbs, bp, busy} = 8'h00;
    reset_n = 1'b0;
    lf = 16'h0029;
    ops = '{OP_SECTOR_ERASE, OP_BLK32_ERASE, OP_BLK64_ERASE,
            OP_CHIP_ERASE_A, OP_CHIP_ERASE_B};
    szc = '{ER_4K, ER_32K, ER_64K, ER_CHIP, ER_CHIP};
    repeat (16) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    set_prot(1'b1, 1'b0, 1'b0, 1'b0, 3'h0);
    erase(0, 22'h100000, 0);
    set_prot(1'b0, 1'b0, 1'b0, 1'b0, 3'h0);
    erase(0, 22'h100000, 1);
    set_prot(1'b1, 1'b0, 1'b0, 1'b0, 3'h7);
    frame(8, {OP_GLB_UNLOCK, 56'h0}, 0, 0, 0, 0);
    erase(0, 22'h051000, 1);
    frame(32, {OP_BLK_LOCK, 24'h050000, 32'h0}, 0, 0, 0, 0);
    erase(0, 22'h051000, 0);
    erase(0, 22'h061000, 1);
    frame(32, {OP_BLK_UNLOCK, 24'h050000, 32'h0}, 0, 0, 0, 0);
    erase(0, 22'h051000, 1);
    frame(8, {OP_GLB_LOCK, 56'h0}, 0, 0, 0, 0);
    erase(0, 22'h061000, 0);
    frame(8, {OP_GLB_UNLOCK, 56'h0}, 0, 0, 0, 0);
    do_reset();
    erase(2, 22'h200000, 0);
    set_prot(1'b0, 1'b0, 1'b0, 1'b0, 3'h0);
    frame(31, {OP_SECTOR_ERASE, 56'h0}, 0, 1, 0, 0);
    frame(33, {OP_SECTOR_ERASE, 56'h0}, 0, 1, 0, 0);
    frame(16, {OP_SECTOR_ERASE, 56'h0}, 0, 1, 0, 0);
    frame(32, {OP_PAGE_PROG, 56'h0}, 0, 1, 0, 0);
    frame(13, {OP_READ, 56'h0}, 0, 0, 0, 0);
    frame(21, {OP_FAST_READ, 56'h0}, 0, 0, 0, 0);
    frame(48, {OP_PAGE_PROG, 24'h001234, 16'ha53c, 16'h0},
          0, 0, 1, 2);
    chk_vec("prog_addr", 24'h001234, {2'h0, pa});
    chk_vec("prog_data", 24'h00003c, {16'h0, pd});
    @(posedge core_clk);
    busy <= 1'b1;
    erase(0, 22'h000000, 0);
    frame(40, {OP_PAGE_PROG, 24'h0, 8'h11, 24'h0}, 0, 1, 0, 0);
    @(posedge core_clk);
    busy <= 1'b0;
    set_prot(1'b0, 1'b1, 1'b0, 1'b0, 3'h1);
    erase(2, 22'h3f0000, 1);
    erase(2, 22'h3e0000, 0);
    for (int i = 0; i < 30; i++) begin
      lf = lfsr(lfsr(lfsr(lf)));
      a = {lf[15:10], lfsr(lf)};
      lf = lfsr(lfsr(lf));
      set_prot(1'b0, lf[0], lf[1], lf[2], lf[5:3]);
      @(posedge core_clk);
      k = lf[8:6] % 5;
      lo = int'(a) & ~(rsize(ops[k]) - 1);
      hi = lo + rsize(ops[k]) - 1;
      if (lf[9]) begin
        hi = int'(a) | 32'hff;
        frame(40, {OP_PAGE_PROG, 2'h0, a, 8'h5a, 24'h0},
              0, hits(a, hi), !hits(a, hi), 1);
      end else begin
        erase(k, a, !hits(lo, hi));
      end
    end
    complete_run();
  end
endmodule // tb
